// ===== hw/fpp_pkg.sv
// Constants and types of the four-phase fetch/execute core.
// Assumes a 16-bit program memory word and an 8-bit data path.
package fpp_pkg;

    localparam int IP_W = 11;
    localparam int IW = 16;
    localparam int DW = 8;
    localparam int DA_W = 6;
    localparam int DM_DEPTH = 64;

    localparam logic [IP_W-1:0] RESET_IP = 11'h000;
    localparam logic [IP_W-1:0] IP_STEP = 11'h001;

    // Instruction fields
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int ROT_LEFT_BIT = 8;
    localparam int DEST_MEM_BIT = 7;
    localparam int IMM_MSB = 7;
    localparam int DADDR_MSB = 5;
    localparam int TARGET_MSB = 10;

    // Opcodes
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_LDA = 4'h1;
    localparam logic [3:0] OP_STA = 4'h2;
    localparam logic [3:0] OP_LDI = 4'h3;
    localparam logic [3:0] OP_ADD = 4'h4;
    localparam logic [3:0] OP_SUB = 4'h5;
    localparam logic [3:0] OP_AND = 4'h6;
    localparam logic [3:0] OP_OR = 4'h7;
    localparam logic [3:0] OP_XOR = 4'h8;
    localparam logic [3:0] OP_ROT = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DEC = 4'hB;
    localparam logic [3:0] OP_SZ = 4'hC;
    localparam logic [3:0] OP_JMP = 4'hD;
    localparam logic [3:0] OP_CALL = 4'hE;
    localparam logic [3:0] OP_RET = 4'hF;

    // Control registers mapped into data memory
    localparam logic [DA_W-1:0] DM_INDIRECT = 6'h00;
    localparam logic [DA_W-1:0] DM_POINTER = 6'h01;
    localparam logic [DA_W-1:0] DM_IP_LOW = 6'h02;
    localparam logic [DA_W-1:0] DM_STATUS = 6'h03;

    localparam int ST_ZERO = 0;
    localparam int ST_CARRY = 1;
    localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] ZERO_STATUS = 2'h0;
    localparam logic [IW-1:0] NOP_WORD = 16'h0000;

    typedef enum logic [3:0]
    {
        FPP_T1 = 4'b0001,
        FPP_T2 = 4'b0010,
        FPP_T3 = 4'b0100,
        FPP_T4 = 4'b1000
    } fpp_phase_t;

    typedef enum logic [3:0]
    {
        FPP_ALU_PASS = 4'h0,
        FPP_ALU_ADD = 4'h1,
        FPP_ALU_SUB = 4'h2,
        FPP_ALU_AND = 4'h3,
        FPP_ALU_OR = 4'h4,
        FPP_ALU_XOR = 4'h5,
        FPP_ALU_RR = 4'h6,
        FPP_ALU_RL = 4'h7,
        FPP_ALU_INC = 4'h8,
        FPP_ALU_DEC = 4'h9
    } fpp_aluop_t;

endpackage

// ===== hw/fpp_alu.sv
// 8-bit arithmetic-logic unit of the four-phase core.
// Purely combinational; the core registers its result.
`timescale 1ns/10ps
module fpp_alu
(
    input wire fpp_pkg::fpp_aluop_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] y,
    output logic cout,
    output logic zero
);

    logic [8:0] sum;
    logic [8:0] diff;

    assign sum = {1'b0, a} + {1'b0, b};
    // Carry set means no borrow
    assign diff = {1'b0, a} + {1'b0, ~b} + 9'h001;

    always_comb
    begin
        y = b;
        cout = cin;
        unique case (op)
            fpp_pkg::FPP_ALU_PASS: y = b;
            fpp_pkg::FPP_ALU_ADD:
            begin
                y = sum[7:0];
                cout = sum[8];
            end
            fpp_pkg::FPP_ALU_SUB:
            begin
                y = diff[7:0];
                cout = diff[8];
            end
            fpp_pkg::FPP_ALU_AND: y = a & b;
            fpp_pkg::FPP_ALU_OR: y = a | b;
            fpp_pkg::FPP_ALU_XOR: y = a ^ b;
            fpp_pkg::FPP_ALU_RR: y = {b[0], b[7:1]};
            fpp_pkg::FPP_ALU_RL: y = {b[6:0], b[7]};
            fpp_pkg::FPP_ALU_INC: y = b + 8'h01;
            fpp_pkg::FPP_ALU_DEC: y = b - 8'h01;
            default:
            begin
                y = b;
                cout = cin;
            end
        endcase
    end

    assign zero = (y == 8'h00);

endmodule

// ===== hw/fpp_core.sv
// Four-phase fetch/execute sequencing core with accumulator datapath.
// Assumes program memory answers instruction_pointer combinationally
// within phase T1; inputs are synchronous to clk.
//
// Summary of operation
// - Main clock is divided into four non-overlapping phase clocks.
// - Pointer advances at start of phase one; new word fetched then.
// - Phases two to four decode and execute the current instruction.
// - One pass through the four phases forms one instruction cycle.
// - Next instruction is fetched while current executes; one per cycle.
// - Instructions loading the pointer take one extra cycle, two total.
// - Branch: first cycle gets target, second fetches it and branches.
// - 8-bit ALU does arithmetic, logic, rotate, inc, dec, branch tests.
// - A single accumulator feeds the ALU; results go to it or to data memory.
// - Control registers sit in data memory, direct and indirect.
// - Taken skip discards the prefetched word; a dummy cycle follows.
// - Reset loads pointer with zero; execution starts there.
`timescale 1ns/10ps
module fpp_core
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] imem_data,
    output logic [3:0] instruction_phase_clocks,
    output logic [10:0] instruction_pointer,
    output logic [7:0] acc_out,
    output logic [1:0] status_out,
    output logic exec_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic fpp_loads_ip(input logic [3:0] op);
        fpp_loads_ip = (op == fpp_pkg::OP_JMP) || (op == fpp_pkg::OP_CALL)
            || (op == fpp_pkg::OP_RET);
    endfunction

    function automatic logic fpp_reads_mem(input logic [3:0] op);
        fpp_reads_mem = (op != fpp_pkg::OP_NOP) && (op != fpp_pkg::OP_LDI)
            && (op != fpp_pkg::OP_STA) && !fpp_loads_ip(op);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    fpp_pkg::fpp_phase_t phase;
    fpp_pkg::fpp_phase_t next_phase;
    logic [10:0] ip;
    logic [10:0] ret_ip;
    logic [15:0] fetch_word;
    logic [15:0] ir;
    logic ir_valid;
    logic [7:0] acc;
    logic [7:0] pointer;
    logic [1:0] status;
    logic [7:0] operand;
    logic [7:0] result;
    logic result_c;
    logic result_z;
    logic [7:0] dmem [0:fpp_pkg::DM_DEPTH-1];

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire [3:0] op = ir[fpp_pkg::OP_MSB:fpp_pkg::OP_LSB];
    wire dest_mem = ir[fpp_pkg::DEST_MEM_BIT];
    wire [5:0] dir_addr = ir[fpp_pkg::DADDR_MSB:0];
    wire [7:0] imm = ir[fpp_pkg::IMM_MSB:0];
    wire [10:0] target = ir[fpp_pkg::TARGET_MSB:0];
    // Indirect slot reaches the cell named by the pointer register
    wire [5:0] eff_addr = (dir_addr == fpp_pkg::DM_INDIRECT)
        ? pointer[fpp_pkg::DADDR_MSB:0] : dir_addr;

    wire rd_ptr = (eff_addr == fpp_pkg::DM_POINTER);
    wire rd_ipl = (eff_addr == fpp_pkg::DM_IP_LOW);
    wire rd_st = (eff_addr == fpp_pkg::DM_STATUS);
    wire [7:0] mem_rd = rd_ptr ? pointer
        : rd_ipl ? ip[7:0]
        : rd_st ? {6'h00, status}
        : dmem[eff_addr];

    fpp_pkg::fpp_aluop_t alu_op;
    assign alu_op =
        (op == fpp_pkg::OP_ADD) ? fpp_pkg::FPP_ALU_ADD :
        (op == fpp_pkg::OP_SUB) ? fpp_pkg::FPP_ALU_SUB :
        (op == fpp_pkg::OP_AND) ? fpp_pkg::FPP_ALU_AND :
        (op == fpp_pkg::OP_OR) ? fpp_pkg::FPP_ALU_OR :
        (op == fpp_pkg::OP_XOR) ? fpp_pkg::FPP_ALU_XOR :
        (op == fpp_pkg::OP_ROT) ? (ir[fpp_pkg::ROT_LEFT_BIT]
            ? fpp_pkg::FPP_ALU_RL : fpp_pkg::FPP_ALU_RR) :
        (op == fpp_pkg::OP_INC) ? fpp_pkg::FPP_ALU_INC :
        (op == fpp_pkg::OP_DEC) ? fpp_pkg::FPP_ALU_DEC :
        fpp_pkg::FPP_ALU_PASS;

    wire [7:0] alu_b = (op == fpp_pkg::OP_LDI) ? imm
        : (op == fpp_pkg::OP_STA) ? acc : operand;
    wire [7:0] alu_y;
    wire alu_c;
    wire alu_z;

    fpp_alu u_alu
    (
        .op(alu_op),
        .a(acc),
        .b(alu_b),
        .cin(status[fpp_pkg::ST_CARRY]),
        .y(alu_y),
        .cout(alu_c),
        .zero(alu_z)
    );

    ////////////////////////////////////////////////////////////////////////
    // Writeback and flow decisions, acted on at the end of T4

    wire wb_phase = ir_valid && (phase == fpp_pkg::FPP_T4);
    wire is_logic_or_arith = (op >= fpp_pkg::OP_ADD)
        && (op <= fpp_pkg::OP_DEC);
    wire to_mem = (op == fpp_pkg::OP_STA) || (is_logic_or_arith && dest_mem);
    wire to_acc = (op == fpp_pkg::OP_LDA) || (op == fpp_pkg::OP_LDI)
        || (is_logic_or_arith && !dest_mem);
    wire wr_ipl = to_mem && (eff_addr == fpp_pkg::DM_IP_LOW);
    wire skip_taken = (op == fpp_pkg::OP_SZ) && result_z;
    // Any change of flow throws away the word prefetched meanwhile
    wire redirect = wb_phase && (fpp_loads_ip(op) || wr_ipl
        || skip_taken);
    wire [10:0] redirect_ip =
        (op == fpp_pkg::OP_RET) ? ret_ip :
        wr_ipl ? {ip[10:8], result} :
        skip_taken ? ip + fpp_pkg::IP_STEP :
        target;
    wire [10:0] next_ip = redirect ? redirect_ip
        : ip + fpp_pkg::IP_STEP;

    assign next_phase = (phase == fpp_pkg::FPP_T1) ? fpp_pkg::FPP_T2
        : (phase == fpp_pkg::FPP_T2) ? fpp_pkg::FPP_T3
        : (phase == fpp_pkg::FPP_T3) ? fpp_pkg::FPP_T4
        : fpp_pkg::FPP_T1;

    ////////////////////////////////////////////////////////////////////////
    // Phase generator; reset parks it in T1

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase <= fpp_pkg::FPP_T1;
        else
            phase <= next_phase;
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch side: pointer moves entering T1, word caught at end of T1

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ip <= fpp_pkg::RESET_IP;
            fetch_word <= fpp_pkg::NOP_WORD;
        end
        else
        begin
            if (phase == fpp_pkg::FPP_T4)
                ip <= next_ip;
            if (phase == fpp_pkg::FPP_T1)
                fetch_word <= imem_data;
        end
    end

    // Prefetched word becomes current at the cycle boundary, unless the
    // flow changed; then a dummy cycle runs while the target is fetched
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ir <= fpp_pkg::NOP_WORD;
            ir_valid <= 1'b0;
        end
        else if (phase == fpp_pkg::FPP_T4)
        begin
            ir <= fetch_word;
            ir_valid <= !redirect;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execute side: operand in T2, ALU in T3, writeback in T4

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            operand <= fpp_pkg::ZERO_BYTE;
            result <= fpp_pkg::ZERO_BYTE;
            result_c <= 1'b0;
            result_z <= 1'b0;
        end
        else
        begin
            if (phase == fpp_pkg::FPP_T2 && fpp_reads_mem(op))
                operand <= mem_rd;
            if (phase == fpp_pkg::FPP_T3)
            begin
                result <= alu_y;
                result_c <= alu_c;
                result_z <= alu_z;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc <= fpp_pkg::ZERO_BYTE;
            status <= fpp_pkg::ZERO_STATUS;
            pointer <= fpp_pkg::ZERO_BYTE;
            ret_ip <= fpp_pkg::RESET_IP;
        end
        else if (wb_phase)
        begin
            if (to_acc)
                acc <= result;
            if (is_logic_or_arith)
            begin
                status[fpp_pkg::ST_ZERO] <= result_z;
                status[fpp_pkg::ST_CARRY] <= result_c;
            end
            if (to_mem && eff_addr == fpp_pkg::DM_STATUS)
                status <= result[1:0];
            if (to_mem && eff_addr == fpp_pkg::DM_POINTER)
                pointer <= result;
            // Return point is the word after the call
            if (op == fpp_pkg::OP_CALL)
                ret_ip <= ip;
        end
    end

    // General cells carry no reset, as in a RAM
    always_ff @(posedge clk)
    begin
        if (wb_phase && to_mem && eff_addr > fpp_pkg::DM_STATUS)
            dmem[eff_addr] <= result;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign instruction_phase_clocks = phase;
    assign instruction_pointer = ip;
    assign acc_out = acc;
    assign status_out = status;
    assign exec_valid = ir_valid;

endmodule

// ===== bench/fpp_prog_mem.sv
// Program memory model that answers the fetch port of the core.
// Assumes the bench preloads words through hierarchical writes to mem.
`timescale 1ns/10ps
module fpp_prog_mem
(
    input wire logic [10:0] instruction_pointer,
    input wire logic [3:0] instruction_phase_clocks,
    output logic [15:0] imem_data
);
    logic [15:0] mem [0:2047];

    ////////////////////////////////////////////////////////////////////
    // A word is only promised during T1; show its inverse elsewhere so
    // that a late fetch cannot pass by luck
    assign imem_data = (instruction_phase_clocks == 4'h1) ?
        mem[instruction_pointer] : ~mem[instruction_pointer];
endmodule

// ===== bench/fpp_core_assertions.sv
// Checker of the four-phase core, attached to its ports by bind.
// Assumes a single clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
module fpp_core_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] imem_data,
    input wire logic [3:0] instruction_phase_clocks,
    input wire logic [10:0] instruction_pointer,
    input wire logic [7:0] acc_out,
    input wire logic [1:0] status_out,
    input wire logic exec_valid
);
    wire logic [3:0] ph = instruction_phase_clocks;
    wire logic [10:0] jump_target = imem_data[10:0];

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////
    a_phase_onehot: assert property ($onehot(ph))
        else $error("phase clocks not one-hot");
    // Sampled rst guards the release edge, where the core is still held
    a_phase_shift: assert property (
        (!rst && ph != 4'h8) |=> (ph == ($past(ph) << 1)))
        else $error("phase did not advance by one");
    a_phase_wrap: assert property (ph == 4'h8 |=> ph == 4'h1)
        else $error("T4 not followed by T1");
    a_pointer_hold: assert property (
        ph != 4'h1 |-> $stable(instruction_pointer))
        else $error("pointer moved outside T1 entry");
    a_result_hold: assert property (
        ph != 4'h1 |-> $stable(acc_out) && $stable(status_out))
        else $error("accumulator or status moved mid cycle");
    a_valid_hold: assert property (
        ph != 4'h1 |-> $stable(exec_valid))
        else $error("valid flag moved mid cycle");
    a_reset_start: assert property (
        $fell(rst) |-> ph == 4'h1 && instruction_pointer == 11'h000
            && !exec_valid)
        else $error("wrong state at reset release");
    a_reset_fetch: assert property (
        $fell(rst) |-> ##4 (instruction_pointer == 11'h001 && exec_valid))
        else $error("first cycle after reset not a fetch of zero");
    a_jump_target: assert property (
        (ph == 4'h1 && imem_data[15:12] == fpp_pkg::OP_JMP) ##4 exec_valid
        |-> ##4 (!exec_valid && instruction_pointer == $past(jump_target, 8)))
        else $error("jump not taken with one dummy cycle");
endmodule

bind fpp_core fpp_core_checker chk
(
    .clk(clk),
    .rst(rst),
    .imem_data(imem_data),
    .instruction_phase_clocks(instruction_phase_clocks),
    .instruction_pointer(instruction_pointer),
    .acc_out(acc_out),
    .status_out(status_out),
    .exec_valid(exec_valid)
);

// ===== bench/test_four_phase_fetch_execute_pipeline.sv
// Self-checking bench of the four-phase core and its program memory.
// Assumes fpp_core, fpp_prog_mem and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(name, want, got) \
    n_compared++; \
    if ((got) !== (want)) \
    begin \
        miscompares++; \
        $display("wrong value %s expected %h seen %h", name, want, got); \
    end

module test_four_phase_fetch_execute_pipeline;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] imem_data;
    logic [3:0] ph;
    logic [10:0] ip;
    logic [7:0] acc;
    logic [1:0] status;
    logic exec_valid;
    logic [21:0] notes [$];
    logic [21:0] want;
    int miscompares = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    fpp_core dut
    (
        .clk(clk),
        .rst(rst),
        .imem_data(imem_data),
        .instruction_phase_clocks(ph),
        .instruction_pointer(ip),
        .acc_out(acc),
        .status_out(status),
        .exec_valid(exec_valid)
    );

    fpp_prog_mem pmem
    (
        .instruction_pointer(ip),
        .instruction_phase_clocks(ph),
        .imem_data(imem_data)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic note(input logic [10:0] a, input logic v,
                        input logic [1:0] f, input logic [7:0] d);
        notes.push_back({a, v, f, d});
    endtask

    task automatic run_program();
        logic [7:0] r;
        logic [7:0] s;
        logic [8:0] sum;
        logic [1:0] st;
        logic [1:0] sb;
        int i;
        @(posedge clk);
        rst <= 1'b1;
        r = 8'($urandom());
        sum = {1'b0, r} + 9'h05A;
        s = sum[7:0];
        // Flags are carry then zero; carry after a subtract means no borrow
        st = {sum[8], s == 8'h00};
        sb = {s >= 8'h5A, r == 8'h00};
        for (i = 0; i < 2048; i++)
            pmem.mem[i] = fpp_pkg::NOP_WORD;
        // Load, store, clear by xor, store, skip on zero, jump
        pmem.mem[0] = 16'h305A;
        pmem.mem[1] = 16'h2004;
        pmem.mem[2] = 16'h8004;
        pmem.mem[3] = 16'h2005;
        pmem.mem[4] = 16'hC005;
        pmem.mem[5] = 16'h30FF;
        pmem.mem[6] = 16'hD010;
        pmem.mem[7] = 16'h3011;
        // Random load, add stored byte, jump on
        pmem.mem[16] = {8'h30, r};
        pmem.mem[17] = 16'h4004;
        pmem.mem[18] = 16'hD020;
        // Call a subtract and return; status write, pointer set, indirect
        // load, rotates, memory destinations, pointer-low read, untaken
        // skip, then a page jump by pointer-low write into a loop
        pmem.mem[32] = 16'hE030;
        pmem.mem[33] = 16'h3002;
        pmem.mem[34] = 16'h2003;
        pmem.mem[35] = 16'h3004;
        pmem.mem[36] = 16'h2001;
        pmem.mem[37] = 16'h1000;
        pmem.mem[38] = 16'h9100;
        pmem.mem[39] = 16'h9084;
        pmem.mem[40] = 16'h7004;
        pmem.mem[41] = 16'h6084;
        pmem.mem[42] = 16'hA004;
        pmem.mem[43] = 16'hB084;
        pmem.mem[44] = 16'h1002;
        pmem.mem[45] = 16'hC004;
        pmem.mem[46] = 16'h3040;
        pmem.mem[47] = 16'h2002;
        pmem.mem[48] = 16'h5004;
        pmem.mem[49] = 16'hF000;
        pmem.mem[64] = 16'hD040;
        repeat (20) @(posedge clk);
        note(11'h000, 1'b0, 2'h0, 8'h00);
        note(11'h001, 1'b1, 2'h0, 8'h00);
        note(11'h002, 1'b1, 2'h0, 8'h5A);
        note(11'h003, 1'b1, 2'h0, 8'h5A);
        note(11'h004, 1'b1, 2'h1, 8'h00);
        note(11'h005, 1'b1, 2'h1, 8'h00);
        note(11'h006, 1'b0, 2'h1, 8'h00);
        note(11'h007, 1'b1, 2'h1, 8'h00);
        note(11'h010, 1'b0, 2'h1, 8'h00);
        note(11'h011, 1'b1, 2'h1, 8'h00);
        note(11'h012, 1'b1, 2'h1, r);
        note(11'h013, 1'b1, st, s);
        note(11'h020, 1'b0, st, s);
        note(11'h021, 1'b1, st, s);
        note(11'h030, 1'b0, st, s);
        note(11'h031, 1'b1, st, s);
        note(11'h032, 1'b1, sb, r);
        note(11'h021, 1'b0, sb, r);
        note(11'h022, 1'b1, sb, r);
        note(11'h023, 1'b1, sb, 8'h02);
        note(11'h024, 1'b1, 2'h2, 8'h02);
        note(11'h025, 1'b1, 2'h2, 8'h04);
        note(11'h026, 1'b1, 2'h2, 8'h04);
        note(11'h027, 1'b1, 2'h2, 8'h5A);
        note(11'h028, 1'b1, 2'h2, 8'hB4);
        note(11'h029, 1'b1, 2'h2, 8'hB4);
        note(11'h02A, 1'b1, 2'h2, 8'hBD);
        note(11'h02B, 1'b1, 2'h2, 8'hBD);
        note(11'h02C, 1'b1, 2'h2, 8'h2E);
        note(11'h02D, 1'b1, 2'h2, 8'h2E);
        note(11'h02E, 1'b1, 2'h2, 8'h2D);
        note(11'h02F, 1'b1, 2'h2, 8'h2D);
        note(11'h030, 1'b1, 2'h2, 8'h40);
        note(11'h040, 1'b0, 2'h2, 8'h40);
        note(11'h041, 1'b1, 2'h2, 8'h40);
        note(11'h040, 1'b0, 2'h2, 8'h40);
        rst <= 1'b0;
        for (i = 0; i < 200 && notes.size() > 0; i++)
            @(posedge clk);
        if (notes.size() != 0)
        begin
            miscompares++;
            conclude();
        end
    endtask

    // One note per instruction cycle, taken while T1 is settled
    always @(negedge clk)
    begin
        if (!rst && ph === 4'h1 && notes.size() > 0)
        begin
            want = notes.pop_front();
            `CHK("pointer", want[21:11], ip)
            `CHK("valid", want[10], exec_valid)
            `CHK("status", want[9:8], status)
            `CHK("accumulator", want[7:0], acc)
        end
    end

    initial
    begin
        void'($urandom(67354));
        run_program();
        run_program();
        conclude();
    end
endmodule
